// ==== common/pcp_pkg.sv ====
package pcp_pkg;
  // clock rate and timing
  localparam int unsigned CLK_HZ          = 40000000;
  localparam int unsigned LONG_PRESS_S    = 4;
  localparam int unsigned LONG_PRESS_CYC  = LONG_PRESS_S * CLK_HZ;
  localparam int unsigned IDLE_DEF_S      = 60;
  localparam int unsigned IDLE_DEF_CYC    = IDLE_DEF_S * CLK_HZ;
  localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / 2;
  localparam int unsigned PULSES_PER_TURN = 50;
  // process image layout
  localparam int unsigned NUM_FKEYS    = 18;
  localparam int unsigned NUM_DKEYS    = 32;
  localparam int unsigned CNT_W        = 8;
  localparam logic [7:0]  CNT_RESET    = 8'h00;
  localparam int unsigned LOCK_LO_BIT  = 0;
  localparam int unsigned LOCK_HI_BIT  = 1;
  localparam int unsigned LBTN_IN_BIT  = 2;
  localparam int unsigned RBTN_IN_BIT  = 4;
  localparam int unsigned LBTN_OUT_BIT = 1;
  localparam int unsigned RBTN_OUT_BIT = 2;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  // power states, one-hot
  typedef enum logic [3:0] {
    PCP_OFF  = 4'h1,
    PCP_ON   = 4'h2,
    PCP_DIM  = 4'h4,
    PCP_DARK = 4'h8
  } pcp_state_t;
endpackage

// ==== rtl/pcp_panel.sv ====
`timescale 1ns/10ps
// What this block does
// - idle timeout steps on to dim to dark
// - dim lowers brightness; touch, or function key while a project runs, wakes
// - short press cycles off on dark on
// - four second hold terminates project, off
// - dark disables screen, function keys, wheel, buttons
// - power lamp off, steady, or flashing
// - dark state refuses wired network connections
// - function keys 1-18 packed into n..n+2
// - byte n+3 holds lock and button bits
// - controller output bytes drive key lamps
// - key pressed reads one; lamp lit on one
// - lock bits encode middle, clockwise, counter
// - button bits one while pressed; lamps steady
// - wheel counters zero after start-up
// - forward pulses n+4, backward n+5
// - counters wrap 255 to 0
// - fifty pulses per full turn
// - direct-key bits in bytes n+6..n+9
// - controls inert unless project running; direct keys always reported
module pcp_panel #(
  parameter int unsigned LONG_CYC  = pcp_pkg::LONG_PRESS_CYC,
  parameter int unsigned IDLE_CYC  = pcp_pkg::IDLE_DEF_CYC,
  parameter int unsigned FLASH_CYC = pcp_pkg::FLASH_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        power_button,
  input  wire logic        touch_activity,
  input  wire logic        project_running,
  input  wire logic        battery_ok,
  input  wire logic [17:0] fkey_in,
  input  wire logic        lock_low,
  input  wire logic        lock_high,
  input  wire logic        left_lamp_button,
  input  wire logic        right_lamp_button,
  input  wire logic        wheel_fwd_pulse,
  input  wire logic        wheel_bwd_pulse,
  input  wire logic [31:0] direct_keys_in,
  input  wire logic [7:0]  out_byte0,
  input  wire logic [7:0]  out_byte1,
  input  wire logic [7:0]  out_byte2,
  input  wire logic [7:0]  out_byte3,
  output logic [7:0]       in_byte0,
  output logic [7:0]       in_byte1,
  output logic [7:0]       in_byte2,
  output logic [7:0]       in_byte3,
  output logic [7:0]       in_byte4,
  output logic [7:0]       in_byte5,
  output logic [7:0]       in_byte6,
  output logic [7:0]       in_byte7,
  output logic [7:0]       in_byte8,
  output logic [7:0]       in_byte9,
  output logic [17:0]      fkey_lamp,
  output logic             left_lamp,
  output logic             right_lamp,
  output logic             power_indicator,
  output logic             charge_indicator,
  output logic             screen_on,
  output logic             screen_dim,
  output logic             controls_enable,
  output logic             net_accept,
  output logic             project_stop
);

  // elaboration checks on the timing counts
  if (LONG_CYC < 2) begin : g_bad_long
    $error("pcp_panel: long press count too small");
  end
  if (IDLE_CYC < 2) begin : g_bad_idle
    $error("pcp_panel: idle count too small");
  end
  if (FLASH_CYC < 1) begin : g_bad_flash
    $error("pcp_panel: flash count too small");
  end

  ////////////////////////////////////////////////////////////////////////
  // state record
  // one record, filled by one process and registered by another

  typedef struct packed {
    pcp_pkg::pcp_state_t st;
    logic [31:0]         hold_cnt;
    logic                long_done;
    logic                btn_prev;
    logic [31:0]         idle_cnt;
    logic [31:0]         flash_cnt;
    logic                flash;
    logic [7:0]          fwd_cnt;
    logic [7:0]          bwd_cnt;
    logic [79:0]         img;
    logic [17:0]         fkey_lamp;
    logic                left_lamp;
    logic                right_lamp;
    logic                pwr_led;
    logic                chg_led;
    logic                scr_on;
    logic                scr_dim;
    logic                ctl_en;
    logic                net_ok;
    logic                stop;
  } pcp_regs_t;

  pcp_regs_t r_r;
  pcp_regs_t r_nxt;

  // wrap-around eight-bit increment
  function automatic logic [7:0] pcp_wrap_inc(input logic [7:0] v);
    pcp_wrap_inc = v + 8'h01;
  endfunction

  // awake states, where the screen and controls may run
  function automatic logic pcp_awake(input pcp_pkg::pcp_state_t s);
    pcp_awake = (s == pcp_pkg::PCP_ON) || (s == pcp_pkg::PCP_DIM);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    logic       powered;
    logic       active;
    logic       short_press;
    logic       ctl;
    logic [7:0] b3;
    // locals first, so no path leaves one unset
    powered     = 1'b0;
    active      = 1'b0;
    ctl         = 1'b0;
    b3          = pcp_pkg::BYTE_ZERO;
    // release before the hold limit is short
    short_press = r_r.btn_prev && !power_button && !r_r.long_done;
    r_nxt = r_r;
    r_nxt.stop = 1'b0;
    r_nxt.btn_prev = power_button;
    powered = (r_r.st != pcp_pkg::PCP_OFF);
    ctl = pcp_awake(r_r.st) && project_running;
    active = touch_activity || (ctl && (|fkey_in || left_lamp_button
             || right_lamp_button || wheel_fwd_pulse || wheel_bwd_pulse
             || lock_low || lock_high));

    // hold timer on the power button
    // a hold in off does nothing; its release counts as a short press
    if (power_button) begin
      if (r_r.hold_cnt < LONG_CYC) begin
        r_nxt.hold_cnt = r_r.hold_cnt + 32'h1;
      end
    end else begin
      r_nxt.hold_cnt  = '0;
      r_nxt.long_done = 1'b0;
    end

    // idle timer
    // saturates, so a long stay in dark cannot wrap into a false dim
    if (active || short_press) begin
      r_nxt.idle_cnt = '0;
    end else if (r_r.idle_cnt < IDLE_CYC) begin
      r_nxt.idle_cnt = r_r.idle_cnt + 32'h1;
    end

    // long hold forces off
    // long_done holds until release, so that release is no press
    if (power_button && !r_r.long_done && r_r.hold_cnt == LONG_CYC - 1
        && powered) begin
      r_nxt.st        = pcp_pkg::PCP_OFF;
      r_nxt.long_done = 1'b1;
      r_nxt.stop      = 1'b1;
    end else begin
      unique case (r_r.st)
        pcp_pkg::PCP_OFF: begin
          if (short_press) begin
            r_nxt.st = pcp_pkg::PCP_ON;
          end
        end
        pcp_pkg::PCP_ON: begin
          if (short_press) begin
            r_nxt.st = pcp_pkg::PCP_DARK;
          end else if (!active && r_r.idle_cnt == IDLE_CYC - 1) begin
            r_nxt.st       = pcp_pkg::PCP_DIM;
            r_nxt.idle_cnt = '0;
          end
        end
        pcp_pkg::PCP_DIM: begin
          if (short_press) begin
            r_nxt.st = pcp_pkg::PCP_DARK;
          end else if (touch_activity || (project_running && |fkey_in)) begin
            r_nxt.st = pcp_pkg::PCP_ON;
          end else if (r_r.idle_cnt == IDLE_CYC - 1) begin
            r_nxt.st = pcp_pkg::PCP_DARK;
          end
        end
        pcp_pkg::PCP_DARK: begin
          if (short_press) begin
            r_nxt.st = pcp_pkg::PCP_ON;
          end
        end
      endcase
    end

    // flash divider for the power lamp
    // free-running, so the dark blink may start at any phase
    if (r_r.flash_cnt >= FLASH_CYC - 1) begin
      r_nxt.flash_cnt = '0;
      r_nxt.flash     = ~r_r.flash;
    end else begin
      r_nxt.flash_cnt = r_r.flash_cnt + 32'h1;
    end

    // wheel counters, one count per pulse
    // pulses while dark or without a project are dropped
    if (ctl && wheel_fwd_pulse) begin
      r_nxt.fwd_cnt = pcp_wrap_inc(r_r.fwd_cnt);
    end
    if (ctl && wheel_bwd_pulse) begin
      r_nxt.bwd_cnt = pcp_wrap_inc(r_r.bwd_cnt);
    end

    b3[pcp_pkg::LOCK_LO_BIT] = lock_low;
    b3[pcp_pkg::LOCK_HI_BIT] = lock_high;
    b3[pcp_pkg::LBTN_IN_BIT] = left_lamp_button;
    b3[pcp_pkg::RBTN_IN_BIT] = right_lamp_button;
    // controls report nothing unless running and awake
    if (!ctl) begin
      b3 = pcp_pkg::BYTE_ZERO;
    end
    // process image
    // wheel counts enter the image in the cycle they change
    r_nxt.img = {direct_keys_in, r_nxt.bwd_cnt, r_nxt.fwd_cnt, b3,
                 6'h00, (ctl ? fkey_in : 18'h00000)};

    // lamps from controller bytes
    // other controller bits are never looked at
    r_nxt.fkey_lamp  = ctl ? {out_byte2[1:0], out_byte1, out_byte0}
                           : 18'h00000;
    r_nxt.left_lamp  = ctl && out_byte3[pcp_pkg::LBTN_OUT_BIT];
    r_nxt.right_lamp = ctl && out_byte3[pcp_pkg::RBTN_OUT_BIT];

    unique case (r_nxt.st)
      pcp_pkg::PCP_OFF:  r_nxt.pwr_led = 1'b0;
      pcp_pkg::PCP_DARK: r_nxt.pwr_led = r_nxt.flash;
      pcp_pkg::PCP_ON:   r_nxt.pwr_led = 1'b1;
      pcp_pkg::PCP_DIM:  r_nxt.pwr_led = 1'b1;
    endcase
    r_nxt.chg_led = (r_nxt.st != pcp_pkg::PCP_OFF) && battery_ok;
    r_nxt.scr_on  = pcp_awake(r_nxt.st);
    r_nxt.scr_dim = (r_nxt.st == pcp_pkg::PCP_DIM);
    r_nxt.ctl_en  = r_nxt.scr_on && project_running;
    // no network in dark
    // follows the screen, so refused in off as well
    r_nxt.net_ok  = r_nxt.scr_on;
  end

  ////////////////////////////////////////////////////////////////////////
  // register
  // one synchronous reset clears the record and loads PCP_OFF into the state

  always_ff @(posedge clk) begin
    if (!resetn) begin
      r_r    <= '0;
      r_r.st <= pcp_pkg::PCP_OFF;
    end else begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  // every port is a plain slice of the registered record

  assign in_byte0         = r_r.img[7:0];
  assign in_byte1         = r_r.img[15:8];
  assign in_byte2         = r_r.img[23:16];
  assign in_byte3         = r_r.img[31:24];
  assign in_byte4         = r_r.img[39:32];
  assign in_byte5         = r_r.img[47:40];
  assign in_byte6         = r_r.img[55:48];
  assign in_byte7         = r_r.img[63:56];
  assign in_byte8         = r_r.img[71:64];
  assign in_byte9         = r_r.img[79:72];
  assign fkey_lamp        = r_r.fkey_lamp;
  assign left_lamp        = r_r.left_lamp;
  assign right_lamp       = r_r.right_lamp;
  assign power_indicator  = r_r.pwr_led;
  assign charge_indicator = r_r.chg_led;
  assign screen_on        = r_r.scr_on;
  assign screen_dim       = r_r.scr_dim;
  assign controls_enable  = r_r.ctl_en;
  assign net_accept       = r_r.net_ok;
  assign project_stop     = r_r.stop;

endmodule

// ==== sim/pcp_panel_asserts.sv ====
`timescale 1ns/10ps
// watches the panel ports for power and image relations
module pcp_panel_asserts (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        power_button,
  input wire logic        touch_activity,
  input wire logic        project_running,
  input wire logic [17:0] fkey_in,
  input wire logic        wheel_fwd_pulse,
  input wire logic [7:0]  in_byte0,
  input wire logic [7:0]  in_byte2,
  input wire logic [7:0]  in_byte3,
  input wire logic [7:0]  in_byte4,
  input wire logic [7:0]  in_byte5,
  input wire logic [17:0] fkey_lamp,
  input wire logic        left_lamp,
  input wire logic        right_lamp,
  input wire logic        screen_on,
  input wire logic        screen_dim,
  input wire logic        power_indicator,
  input wire logic        net_accept,
  input wire logic        project_stop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // fully on with a project and the power button released
  sequence s_run;
    project_running && screen_on && !screen_dim && !power_button;
  endsequence
  sequence s_dark2;
    !screen_on [*2];
  endsequence
  property p_key;
    s_run |=> in_byte0 == $past(fkey_in[7:0]);
  endproperty
  property p_idle;
    !project_running |=> in_byte0 == 8'h00 && in_byte3 == 8'h00;
  endproperty
  property p_pad;
    in_byte2[7:2] == 6'h00 && in_byte3[7:5] == 3'h0 && !in_byte3[3];
  endproperty
  property p_wheel;
    s_run ##0 wheel_fwd_pulse |=> in_byte4 == $past(in_byte4) + 8'h01;
  endproperty
  property p_start;
    $rose(resetn) |-> in_byte4 == 8'h00 && in_byte5 == 8'h00;
  endproperty
  property p_net;
    !screen_on |-> !net_accept;
  endproperty
  property p_dark;
    s_dark2 |-> fkey_lamp == 18'h00000 && !left_lamp && !right_lamp;
  endproperty
  property p_lit;
    screen_on |-> power_indicator;
  endproperty
  property p_wake;
    screen_dim && project_running && touch_activity |=> !screen_dim;
  endproperty
  property p_stop;
    project_stop |=> !project_stop && !screen_on && !power_indicator;
  endproperty
  a_key:   assert property (p_key)   else $error("key byte wrong");
  a_idle:  assert property (p_idle)  else $error("image not idle");
  a_pad:   assert property (p_pad)   else $error("spare bits set");
  a_wheel: assert property (p_wheel) else $error("wheel count off");
  a_start: assert property (p_start) else $error("counts not zero");
  a_net:   assert property (p_net)   else $error("net accepted");
  a_dark:  assert property (p_dark)  else $error("lamps in dark");
  a_lit:   assert property (p_lit)   else $error("power lamp off");
  a_wake:  assert property (p_wake)  else $error("dim not woken");
  a_stop:  assert property (p_stop)  else $error("stop not off");
endmodule
bind pcp_panel pcp_panel_asserts u_chk (.clk, .resetn, .power_button,
  .touch_activity, .project_running, .fkey_in, .wheel_fwd_pulse,
  .in_byte0, .in_byte2, .in_byte3, .in_byte4, .in_byte5, .fkey_lamp,
  .left_lamp, .right_lamp, .screen_on, .screen_dim, .power_indicator,
  .net_accept, .project_stop);

// ==== sim/pcp_plc_model.sv ====
`timescale 1ns/10ps
// controller side of the process image
module pcp_plc_model (
  input  wire logic        clk,
  input  wire logic [79:0] img,
  output logic      [31:0] outs
);
  initial outs = 32'h00000000;
  // lamp bytes written on an edge
  task put(input logic [31:0] val);
    @(posedge clk);
    outs <= val;
  endtask
  task get(input int idx, output logic [7:0] val);
    val = img[8*idx +: 8];
  endtask
endmodule

// ==== sim/pcp_panel_tb_top.sv ====
`timescale 1ns/10ps
module pcp_panel_tb_top;
  localparam int          LC = 20;
  localparam int          IC = 30;
  localparam logic [79:0] EXP_IMG = 80'h89ABCDEF_0000_1402A5C3;
  logic        clk = 1'b0, resetn = 1'b0, power_button = 1'b0;
  logic        touch_activity = 1'b1, project_running = 1'b1;
  logic        battery_ok = 1'b1, lock_low = 1'b0, lock_high = 1'b0;
  logic        left_lamp_button = 1'b0, right_lamp_button = 1'b0;
  logic        wheel_fwd_pulse = 1'b0, wheel_bwd_pulse = 1'b0;
  logic [17:0] fkey_in = 18'h00000, fkey_lamp;
  logic [31:0] direct_keys_in = 32'h00000000, plc_out;
  logic [7:0]  in_byte0, in_byte1, in_byte2, in_byte3, in_byte4, v;
  logic [7:0]  in_byte5, in_byte6, in_byte7, in_byte8, in_byte9;
  logic [7:0]  out_byte0, out_byte1, out_byte2, out_byte3;
  logic        left_lamp, right_lamp, power_indicator, charge_indicator;
  logic        screen_on, screen_dim, controls_enable, net_accept;
  logic        project_stop;
  int          n_fail = 0, n_tests = 0, k, hits;
  assign {out_byte3, out_byte2, out_byte1, out_byte0} = plc_out;
  always #12.5 clk = ~clk;
  pcp_panel #(.LONG_CYC(LC), .IDLE_CYC(IC), .FLASH_CYC(3)) uut (.clk,
    .resetn, .power_button, .touch_activity, .project_running,
    .battery_ok, .fkey_in, .lock_low, .lock_high, .left_lamp_button,
    .right_lamp_button, .wheel_fwd_pulse, .wheel_bwd_pulse,
    .direct_keys_in, .out_byte0, .out_byte1, .out_byte2, .out_byte3,
    .in_byte0, .in_byte1, .in_byte2, .in_byte3, .in_byte4, .in_byte5,
    .in_byte6, .in_byte7, .in_byte8, .in_byte9, .fkey_lamp, .left_lamp,
    .right_lamp, .power_indicator, .charge_indicator, .screen_on,
    .screen_dim, .controls_enable, .net_accept, .project_stop);
  pcp_plc_model plc (.clk, .outs(plc_out), .img({in_byte9, in_byte8,
    in_byte7, in_byte6, in_byte5, in_byte4, in_byte3, in_byte2,
    in_byte1, in_byte0}));
  ////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // short press of the power button
  task press(input int n);
    power_button <= 1'b1;
    tick(n);
    power_button <= 1'b0;
    tick(3);
    #1;
  endtask
  task wheel(input int f, input int b);
    repeat (f + b) begin
      wheel_fwd_pulse <= (f > 0);
      wheel_bwd_pulse <= (f == 0);
      tick(1);
      wheel_fwd_pulse <= 1'b0;
      wheel_bwd_pulse <= 1'b0;
      tick(1);
      if (f > 0) f--;
    end
    tick(1);
    #1;
  endtask
  task tally_and_finish;
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    tick(4);
    resetn <= 1'b1;
    tick(1);
    press(2);
    chk(32'({power_indicator, charge_indicator, screen_on}), 32'h7);
    chk(32'(net_accept), 32'h1);
    tick(1);
    fkey_in <= 18'h2A5C3;
    direct_keys_in <= 32'h89ABCDEF;
    left_lamp_button <= 1'b1;
    right_lamp_button <= 1'b1;
    plc.put(32'hFF0601A5);
    tick(2);
    #1;
    // whole image after start-up and key presses
    for (k = 0; k < 10; k++) begin
      plc.get(k, v);
      chk(32'(v), 32'(EXP_IMG[8*k +: 8]));
    end
    chk(32'({fkey_lamp, left_lamp, right_lamp}), 32'h80697);
    chk(32'(controls_enable), 32'h1);
    for (k = 0; k < 3; k++) begin
      tick(1);
      {lock_high, lock_low} <= 2'(k);
      tick(2);
      #1;
      plc.get(3, v);
      chk(32'(v), 32'h14 | 32'(k));
    end
    tick(1);
    wheel(255, 3);
    chk(32'({in_byte4, in_byte5}), 32'hFF03);
    tick(1);
    wheel(1, 0);
    chk(32'(in_byte4), 32'h00);
    tick(1);
    touch_activity <= 1'b0;
    fkey_in <= 18'h00000;
    left_lamp_button <= 1'b0;
    right_lamp_button <= 1'b0;
    {lock_high, lock_low} <= 2'b00;
    tick(IC + 4);
    #1;
    chk(32'({screen_dim, power_indicator}), 32'h3);
    tick(1);
    touch_activity <= 1'b1;
    tick(1);
    touch_activity <= 1'b0;
    tick(2);
    #1;
    chk(32'(screen_dim), 32'h0);
    tick(2 * IC + 6);
    #1;
    chk(32'({screen_on, net_accept, fkey_lamp, left_lamp}), 32'h0);
    chk(32'({controls_enable, right_lamp}), 32'h0);
    v[0] = power_indicator;
    for (k = 0; k < 10 && power_indicator === v[0]; k++) begin
      tick(1);
      #1;
    end
    chk(32'(k < 10), 32'h1);
    tick(1);
    press(2);
    chk(32'(screen_on), 32'h1);
    tick(1);
    press(2);
    chk(32'(screen_on), 32'h0);
    tick(1);
    power_button <= 1'b1;
    hits = 0;
    repeat (LC + 4) begin
      tick(1);
      #1;
      hits += int'(project_stop);
    end
    tick(1);
    press(1);
    chk(32'(hits), 32'h1);
    chk(32'({power_indicator, screen_on, charge_indicator}), 32'h0);
    tick(1);
    project_running <= 1'b0;
    fkey_in <= 18'h3FFFF;
    press(2);
    chk(32'({in_byte0, fkey_lamp}), 32'h0);
    chk(32'({controls_enable, left_lamp, in_byte3}), 32'h0);
    tally_and_finish;
  end
endmodule
